// file: hw/pmd_pkg.sv
package pmd_pkg;

	// =====================================================================
	// Local master status codes
	// =====================================================================
	localparam logic [3:0] ST_IDLE      = 4'h0;
	localparam logic [3:0] ST_ADDR_LOAD = 4'h1;
	localparam logic [3:0] ST_BUS_XACT  = 4'h2;
	localparam logic [3:0] ST_BUS_TERM  = 4'h3;

	// =====================================================================
	// Termination codes
	// =====================================================================
	localparam logic [3:0] TERM_NONE   = 4'h0;
	localparam logic [3:0] TERM_NORMAL = 4'h1;

	// =====================================================================
	// Bus commands and reset values
	// =====================================================================
	localparam logic [3:0]  CMD_DAC      = 4'hd;
	localparam logic [31:0] DATA_RST     = 32'h0000_0000;
	localparam logic [15:0] BURST_RST    = 16'h0000;
	localparam logic [3:0]  CBE_RST      = 4'h0;

	typedef enum logic [2:0] {
		PMD_IDLE  = 3'b000,
		PMD_REQ   = 3'b001,
		PMD_LOAD  = 3'b010,
		PMD_ADLO  = 3'b011,
		PMD_ADHI  = 3'b100,
		PMD_DATA  = 3'b101,
		PMD_TURN  = 3'b110,
		PMD_DONE  = 3'b111
	} pmd_state_e;

	// Start-of-transfer request latched from the local side.
	typedef struct packed {
		logic [63:0] addr;
		logic [3:0]  cmd;
		logic [15:0] len;
	} pmd_req_s;

endpackage

// file: hw/pmd_seq.sv
`timescale 1ns/1ps
module pmd_seq (
	input  wire logic        core_clk,            // PCI clock
	input  wire logic        reset_n,             // Async reset, active low
	input  wire logic        local_req_32_n,      // Local 32-bit request
	input  wire logic        local_ready_in_n,    // Local ready
	input  wire logic [63:0] local_addr_in,       // Starting address
	input  wire logic [3:0]  local_cmd_be_in,     // Command or byte enables
	input  wire logic [15:0] local_burst_len_in,  // Burst length in doublewords
	input  wire logic        gnt_n,               // Bus grant pin
	input  wire logic        trdy_n,              // Target ready pin
	input  wire logic        bus_frame_n,         // Observed framen pin
	input  wire logic        bus_irdy_n,          // Observed irdyn pin
	input  wire logic [31:0] ad_in,               // Address/data pins in
	output logic             req_n,               // Bus request
	output logic             frame_n_o,           // framen drive value
	output logic             frame_oe_n,          // framen enable, low drives
	output logic             irdy_n_o,            // irdyn drive value
	output logic             irdy_oe_n,           // irdyn enable, low drives
	output logic [31:0]      ad_o,                // Address/data drive
	output logic             ad_oe_n,             // ad enable, low drives
	output logic [3:0]       cbe_o,               // Command/byte enables
	output logic             cbe_oe_n,            // cben enable, low drives
	output logic             local_grant_out_n,   // Local grant
	output logic             local_transfer_strobe_n, // Read data valid
	output logic [31:0]      local_data_out,      // Read data to local side
	output logic [15:0]      burst_counter,       // Remaining doublewords
	output logic [3:0]       local_master_state,  // Local status
	output logic [3:0]       termination_code     // Termination status
);

	// =====================================================================
	// Reset release and pin synchronisers
	// =====================================================================
	logic       rst_m_r;
	logic       rst_r;
	logic [4:0] pin_m_r;
	logic [4:0] pin_r;
	logic [31:0] ad_m_r;
	logic [31:0] ad_r;

	always_ff @(posedge core_clk or negedge reset_n) begin
		if (!reset_n) begin
			rst_m_r <= 1'b0;
			rst_r   <= 1'b0;
		end else begin
			rst_m_r <= 1'b1;
			rst_r   <= rst_m_r;
		end
	end

	// Pins are sampled through two stages; this adds latency against the
	// bus but keeps metastability away from the sequencer.
	always_ff @(posedge core_clk or negedge rst_r) begin
		if (!rst_r) begin
			pin_m_r <= 5'h1f;
			pin_r   <= 5'h1f;
			ad_m_r  <= pmd_pkg::DATA_RST;
			ad_r    <= pmd_pkg::DATA_RST;
		end else begin
			pin_m_r <= {gnt_n, trdy_n, bus_frame_n, bus_irdy_n, local_ready_in_n};
			pin_r   <= pin_m_r;
			ad_m_r  <= ad_in;
			ad_r    <= ad_m_r;
		end
	end

	logic gnt_s, trdy_s, frame_s, irdy_s, lrdy_s;
	assign {gnt_s, trdy_s, frame_s, irdy_s, lrdy_s} = pin_r;

	// =====================================================================
	// Sequencer
	// =====================================================================
	pmd_pkg::pmd_state_e state_r, state_nxt;
	pmd_pkg::pmd_req_s   req_r, req_nxt;
	logic        req_n_r, req_n_nxt;
	logic        frame_r, frame_nxt, frame_oe_r, frame_oe_nxt;
	logic        irdy_r, irdy_nxt, irdy_oe_r, irdy_oe_nxt;
	logic [31:0] ad_o_r, ad_o_nxt;
	logic        ad_oe_r, ad_oe_nxt;
	logic [3:0]  cbe_r, cbe_nxt;
	logic        cbe_oe_r, cbe_oe_nxt;
	logic        lgnt_r, lgnt_nxt;
	logic        xfer_r, xfer_nxt;
	logic [31:0] ldata_r, ldata_nxt;
	logic [15:0] cnt_r, cnt_nxt;
	logic [3:0]  stat_r, stat_nxt;
	logic [3:0]  term_r, term_nxt;
	logic        lrdy_d_r;
	logic        phase_done;
	logic [15:0] cnt_left;

	// Count still owed once this cycle's phase is taken. The load and the
	// framen release share it so that they can never disagree.
	function automatic logic [15:0] count_after(input logic [15:0] cnt, input logic done);
		count_after = done ? cnt - 16'h0001 : cnt;
	endfunction

	// Both ready strobes come from one synchronised sample of the wires, so
	// the word held in ad_r belongs to the very phase that is counted.
	assign phase_done = !irdy_s && !trdy_s;
	assign cnt_left   = count_after(cnt_r, phase_done);

	// =====================================================================
	// Next-state logic
	// =====================================================================
	always_comb begin
		state_nxt   = state_r;
		req_nxt     = req_r;
		req_n_nxt   = req_n_r;
		frame_nxt   = frame_r;
		frame_oe_nxt = frame_oe_r;
		irdy_nxt    = irdy_r;
		irdy_oe_nxt = irdy_oe_r;
		ad_o_nxt    = ad_o_r;
		ad_oe_nxt   = ad_oe_r;
		cbe_nxt     = cbe_r;
		cbe_oe_nxt  = cbe_oe_r;
		lgnt_nxt    = lgnt_r;
		xfer_nxt    = 1'b1;
		ldata_nxt   = ldata_r;
		cnt_nxt     = cnt_r;
		stat_nxt    = stat_r;
		term_nxt    = term_r;
		case (state_r)
			pmd_pkg::PMD_IDLE: begin
				// A request is only taken here, so one raised during a burst
				// simply waits until the sequencer is back in idle.
				irdy_oe_nxt = 1'b1;
				if (!local_req_32_n) begin
					req_n_nxt = 1'b0;
					req_nxt   = '{local_addr_in, local_cmd_be_in, local_burst_len_in};
					state_nxt = pmd_pkg::PMD_REQ;
				end
			end
			pmd_pkg::PMD_REQ: begin
				// Grant is honoured only while framen and irdyn both read high,
				// so the tail of another master's transfer is never overrun.
				if (!gnt_s && frame_s && irdy_s) begin
					lgnt_nxt  = 1'b0;
					state_nxt = pmd_pkg::PMD_LOAD;
				end
			end
			pmd_pkg::PMD_LOAD: begin
				stat_nxt  = pmd_pkg::ST_ADDR_LOAD;
				cnt_nxt   = req_r.len;
				state_nxt = pmd_pkg::PMD_ADLO;
			end
			pmd_pkg::PMD_ADLO: begin
				// Address and command reach the pins one cycle after entry,
				// because every output is registered.
				frame_nxt    = 1'b0;
				frame_oe_nxt = 1'b0;
				ad_o_nxt     = req_r.addr[31:0];
				ad_oe_nxt    = 1'b0;
				cbe_nxt      = pmd_pkg::CMD_DAC;
				cbe_oe_nxt   = 1'b0;
				req_n_nxt    = 1'b1;
				state_nxt    = pmd_pkg::PMD_ADHI;
			end
			pmd_pkg::PMD_ADHI: begin
				// The grant is withdrawn here, so the local side sees it from one cycle
				// before the address loading status until that status ends.
				ad_o_nxt  = req_r.addr[63:32];
				cbe_nxt   = req_r.cmd;
				stat_nxt  = pmd_pkg::ST_BUS_XACT;
				lgnt_nxt  = 1'b1;
				state_nxt = pmd_pkg::PMD_DATA;
			end
			pmd_pkg::PMD_DATA: begin
				// The wires are seen two cycles late, so the bus may run a few
				// phases past the count; only synchronised phases are delivered.
				ad_oe_nxt   = 1'b1;
				cbe_nxt     = local_cmd_be_in;
				irdy_oe_nxt = 1'b0;
				irdy_nxt    = lrdy_d_r;
				if (phase_done) begin
					ldata_nxt = ad_r;
					cnt_nxt   = cnt_left;
					// A counted phase means trdyn and irdyn were both low.
					xfer_nxt  = 1'b0;
				end
				// The framen release waits for a cycle in which irdyn stays asserted.
				if (cnt_left == 16'h0001 && !lrdy_d_r) begin
					frame_nxt = 1'b1;
				end
				if (phase_done && cnt_r == 16'h0001) begin
					frame_oe_nxt = 1'b1;
					cbe_oe_nxt   = 1'b1;
					irdy_nxt     = 1'b1;
					stat_nxt     = pmd_pkg::ST_BUS_TERM;
					term_nxt     = pmd_pkg::TERM_NORMAL;
					state_nxt    = pmd_pkg::PMD_TURN;
				end
			end
			pmd_pkg::PMD_TURN: begin
				// The irdyn drive is given up one cycle after it went high, so
				// the wire is never left floating while still low.
				irdy_oe_nxt = 1'b1;
				state_nxt   = pmd_pkg::PMD_DONE;
			end
			pmd_pkg::PMD_DONE: begin
				// One more cycle in the terminating status lets the local master
				// see it before the sequencer returns to idle.
				stat_nxt  = pmd_pkg::ST_IDLE;
				state_nxt = pmd_pkg::PMD_IDLE;
			end
			default: begin
				state_nxt = pmd_pkg::PMD_IDLE;
			end
		endcase
	end

	// =====================================================================
	// Sequencer registers
	// =====================================================================
	// All sequencer state is held here; the next values come from the
	// combinational block above, except lrdy_d_r, which takes lrdy_s.
	always_ff @(posedge core_clk or negedge rst_r) begin
		if (!rst_r) begin
			state_r    <= pmd_pkg::PMD_IDLE;
			req_r      <= '0;
			req_n_r    <= 1'b1;
			frame_r    <= 1'b1;
			frame_oe_r <= 1'b1;
			irdy_r     <= 1'b1;
			irdy_oe_r  <= 1'b1;
			ad_o_r     <= pmd_pkg::DATA_RST;
			ad_oe_r    <= 1'b1;
			cbe_r      <= pmd_pkg::CBE_RST;
			cbe_oe_r   <= 1'b1;
			lgnt_r     <= 1'b1;
			xfer_r     <= 1'b1;
			ldata_r    <= pmd_pkg::DATA_RST;
			cnt_r      <= pmd_pkg::BURST_RST;
			stat_r     <= pmd_pkg::ST_IDLE;
			term_r     <= pmd_pkg::TERM_NONE;
			lrdy_d_r   <= 1'b1;
		end else begin
			state_r    <= state_nxt;
			req_r      <= req_nxt;
			req_n_r    <= req_n_nxt;
			frame_r    <= frame_nxt;
			frame_oe_r <= frame_oe_nxt;
			irdy_r     <= irdy_nxt;
			irdy_oe_r  <= irdy_oe_nxt;
			ad_o_r     <= ad_o_nxt;
			ad_oe_r    <= ad_oe_nxt;
			cbe_r      <= cbe_nxt;
			cbe_oe_r   <= cbe_oe_nxt;
			lgnt_r     <= lgnt_nxt;
			xfer_r     <= xfer_nxt;
			ldata_r    <= ldata_nxt;
			cnt_r      <= cnt_nxt;
			stat_r     <= stat_nxt;
			term_r     <= term_nxt;
			lrdy_d_r   <= lrdy_s;
		end
	end

	// =====================================================================
	// Output drive
	// =====================================================================
	// Every output is a register copy, so the pins see no decode glitches.
	assign req_n                   = req_n_r;
	assign frame_n_o               = frame_r;
	assign frame_oe_n              = frame_oe_r;
	assign irdy_n_o                = irdy_r;
	assign irdy_oe_n               = irdy_oe_r;
	assign ad_o                    = ad_o_r;
	assign ad_oe_n                 = ad_oe_r;
	assign cbe_o                   = cbe_r;
	assign cbe_oe_n                = cbe_oe_r;
	assign local_grant_out_n       = lgnt_r;
	assign local_transfer_strobe_n = xfer_r;
	assign local_data_out          = ldata_r;
	assign burst_counter           = cnt_r;
	assign local_master_state      = stat_r;
	assign termination_code        = term_r;

endmodule

// file: verif/pmd_seq_monitor.sv
`timescale 1ns/1ps
// =====================================================================
// Port checks on the sequencer
// =====================================================================
module pmd_seq_monitor (
	input wire logic        core_clk,                // Clock
	input wire logic        reset_n,                 // Reset
	input wire logic        local_req_32_n,          // Request
	input wire logic        gnt_n,                   // Grant pin
	input wire logic        bus_frame_n,             // framen wire
	input wire logic        bus_irdy_n,              // irdyn wire
	input wire logic        req_n,                   // Bus request
	input wire logic        frame_n_o,               // framen value
	input wire logic        frame_oe_n,              // framen enable
	input wire logic        irdy_n_o,                // irdyn value
	input wire logic        irdy_oe_n,               // irdyn enable
	input wire logic        ad_oe_n,                 // ad enable
	input wire logic [3:0]  cbe_o,                   // Command
	input wire logic        cbe_oe_n,                // cben enable
	input wire logic        local_grant_out_n,       // Local grant
	input wire logic        local_transfer_strobe_n, // Strobe
	input wire logic [15:0] burst_counter,           // Count
	input wire logic [3:0]  local_master_state,      // Status
	input wire logic [3:0]  termination_code         // Termination
);
	default clocking cb @(posedge core_clk); endclocking
	default disable iff (!reset_n);

	sequence s_adlo;
		cbe_o == pmd_pkg::CMD_DAC && !cbe_oe_n && local_master_state == pmd_pkg::ST_ADDR_LOAD;
	endsequence
	sequence s_adhi;
		!ad_oe_n && !frame_n_o && local_master_state == pmd_pkg::ST_BUS_XACT;
	endsequence

	chk_addr_low: assert property (
		$fell(frame_n_o) && !frame_oe_n |-> s_adlo) else $error("low address phase wrong");
	chk_addr_high: assert property (
		$fell(frame_n_o) && !frame_oe_n |=> s_adhi) else $error("high address phase wrong");
	chk_req_follow: assert property (
		!local_req_32_n && req_n && local_master_state == pmd_pkg::ST_IDLE |=> !req_n)
		else $error("bus request late");
	chk_grant_idle: assert property (
		$fell(local_grant_out_n) |-> !$past(gnt_n, 3) && $past(bus_frame_n, 3)
		&& $past(bus_irdy_n, 3))
		else $error("local grant without bus grant");
	chk_grant_load: assert property (
		$fell(local_grant_out_n) |-> ##[0:1] local_master_state == pmd_pkg::ST_ADDR_LOAD)
		else $error("no address loading after grant");
	chk_strobe_count: assert property (
		!local_transfer_strobe_n |-> burst_counter == $past(burst_counter) - 16'h1)
		else $error("count not decremented with strobe");
	chk_frame_end: assert property (
		$rose(frame_n_o) && !frame_oe_n |-> !irdy_n_o && !irdy_oe_n)
		else $error("irdyn not held at last phase");
	chk_turn_status: assert property (
		local_master_state == pmd_pkg::ST_BUS_TERM |-> termination_code == pmd_pkg::TERM_NORMAL
		&& burst_counter == 16'h0 && frame_oe_n && cbe_oe_n && irdy_n_o)
		else $error("turnaround outputs wrong");
	chk_idle_release: assert property (
		$past(local_master_state) == pmd_pkg::ST_BUS_TERM
		&& local_master_state == pmd_pkg::ST_IDLE |-> irdy_oe_n && local_transfer_strobe_n)
		else $error("irdyn or strobe held in idle");
endmodule

bind pmd_seq pmd_seq_monitor pmd_seq_monitor_i (.core_clk(core_clk), .reset_n(reset_n),
	.local_req_32_n(local_req_32_n), .gnt_n(gnt_n), .bus_frame_n(bus_frame_n),
	.bus_irdy_n(bus_irdy_n), .req_n(req_n), .frame_n_o(frame_n_o), .frame_oe_n(frame_oe_n),
	.irdy_n_o(irdy_n_o), .irdy_oe_n(irdy_oe_n), .ad_oe_n(ad_oe_n), .cbe_o(cbe_o),
	.cbe_oe_n(cbe_oe_n), .local_grant_out_n(local_grant_out_n),
	.local_transfer_strobe_n(local_transfer_strobe_n), .burst_counter(burst_counter),
	.local_master_state(local_master_state), .termination_code(termination_code));

// file: verif/pmd_seq_tb.sv
`timescale 1ns/1ps
module pmd_seq_tb;
	logic        core_clk = 1'b0, reset_n = 1'b0, req32_n = 1'b1, rdy_n = 1'b1, slow = 1'b0;
	logic [63:0] addr = 64'h0;
	logic [3:0]  cmd = 4'h0, cbe_o, state, term;
	logic [15:0] len = 16'h0, cnt;
	logic [31:0] ad_in, ad_o, dout;
	logic        gnt_n, trdy_n, frame_w, irdy_w, req_n, fr_o, fr_oe, ir_o, ir_oe;
	logic        ad_oe, cbe_oe, grant_n, xfer_n;
	int          n_errors = 0, check_count = 0;

	pmd_seq pmd_seq_i (.core_clk(core_clk), .reset_n(reset_n), .local_req_32_n(req32_n),
		.local_ready_in_n(rdy_n), .local_addr_in(addr), .local_cmd_be_in(cmd),
		.local_burst_len_in(len), .gnt_n(gnt_n), .trdy_n(trdy_n), .bus_frame_n(frame_w),
		.bus_irdy_n(irdy_w), .ad_in(ad_in), .req_n(req_n), .frame_n_o(fr_o),
		.frame_oe_n(fr_oe), .irdy_n_o(ir_o), .irdy_oe_n(ir_oe), .ad_o(ad_o), .ad_oe_n(ad_oe),
		.cbe_o(cbe_o), .cbe_oe_n(cbe_oe), .local_grant_out_n(grant_n),
		.local_transfer_strobe_n(xfer_n), .local_data_out(dout), .burst_counter(cnt),
		.local_master_state(state), .termination_code(term));
	pmd_target_model pmd_target_model_i (.core_clk(core_clk), .slow(slow), .req_n(req_n),
		.frame_n_o(fr_o), .frame_oe_n(fr_oe), .irdy_n_o(ir_o), .irdy_oe_n(ir_oe),
		.ad_o(ad_o), .ad_oe_n(ad_oe), .gnt_n(gnt_n), .trdy_n(trdy_n),
		.bus_frame_n(frame_w), .bus_irdy_n(irdy_w), .ad_in(ad_in));

	initial forever #25 core_clk = ~core_clk;

	task automatic end_of_test();
		$display("checks %0d errors %0d", check_count, n_errors);
		if (n_errors == 0 && check_count > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask

	task automatic cmp(input string nm, input logic [31:0] e, input logic [31:0] g);
		check_count++;
		if (g !== e) begin
			$display("mismatch %s expected %h seen %h", nm, e, g);
			n_errors++;
		end
	endtask

	// =====================================================================
	// One read burst, seen from the local master
	// =====================================================================
	task automatic burst(input logic [63:0] a, input logic [3:0] c, input logic [15:0] n,
			input logic s, input logic st);
		logic [15:0] got;
		logic        fr;
		int          tail;
		got = 16'h0;
		fr = 1'b1;
		tail = 0;
		slow = s;
		addr = a;
		cmd = c;
		len = n;
		req32_n = 1'b0;
		for (int k = 0; k < 400 && tail < 3; k++) begin
			@(posedge core_clk);
			#1;
			if (grant_n === 1'b0)
				req32_n = 1'b1;
			// The stall is short so the burst still ends well inside the loop bound.
			rdy_n = st && (k % 5 == 2);
			if (fr && fr_oe === 1'b0 && fr_o === 1'b0) begin
				cmp("ad low", a[31:0], ad_o);
				cmp("cbe dac", 32'(pmd_pkg::CMD_DAC), 32'(cbe_o));
				@(posedge core_clk);
				#1;
				cmp("ad high", a[63:32], ad_o);
				cmp("cbe cmd", 32'(c), 32'(cbe_o));
			end
			fr = fr_o | fr_oe;
			if (xfer_n === 1'b0) begin
				cmp("data", 32'ha5a5_0000 + 32'(got), dout);
				got++;
			end
			if (state === pmd_pkg::ST_BUS_TERM) begin
				cmp("term", 32'(pmd_pkg::TERM_NORMAL), 32'(term));
				cmp("count", 32'h0, 32'(cnt));
				tail = 1;
			end else if (tail > 0)
				tail++;
		end
		cmp("words", 32'(n), 32'(got));
		cmp("status", 32'(pmd_pkg::ST_IDLE), 32'(state));
		cmp("irdy oe", 32'h1, 32'(ir_oe));
		repeat (3) @(posedge core_clk);
	endtask

	task automatic t_three_fast();
		burst(64'h0000_0012_3456_7800, 4'h6, 16'h3, 1'b0, 1'b0);
	endtask
	task automatic t_five_slow_stall();
		burst(64'hfedc_ba98_0000_0040, 4'hc, 16'h5, 1'b1, 1'b1);
	endtask
	task automatic t_single();
		burst(64'h8000_0000_ffff_fffc, 4'h6, 16'h1, 1'b0, 1'b0);
	endtask

	initial begin
		repeat (4) @(posedge core_clk);
		#1 reset_n = 1'b1;
		repeat (4) @(posedge core_clk);
		#1;
		t_three_fast();
		t_five_slow_stall();
		t_single();
		end_of_test();
	end

	initial begin
		#(2000 * 50);
		n_errors++;
		end_of_test();
	end
endmodule

// file: verif/pmd_target_model.sv
`timescale 1ns/1ps
// =====================================================================
// Bus target and arbiter
// =====================================================================
module pmd_target_model #(
	parameter logic [31:0] BASE = 32'ha5a5_0000
) (
	input  wire logic        core_clk,    // Clock
	input  wire logic        slow,        // Wait states on
	input  wire logic        req_n,       // Request
	input  wire logic        frame_n_o,   // framen value
	input  wire logic        frame_oe_n,  // framen enable
	input  wire logic        irdy_n_o,    // irdyn value
	input  wire logic        irdy_oe_n,   // irdyn enable
	input  wire logic [31:0] ad_o,        // ad value
	input  wire logic        ad_oe_n,     // ad enable
	output logic             gnt_n,       // Grant
	output logic             trdy_n,      // Target ready
	output logic             bus_frame_n, // framen wire
	output logic             bus_irdy_n,  // irdyn wire
	output logic [31:0]      ad_in        // ad wire
);
	logic [15:0] idx_r = 16'h0;
	logic        sel_r = 1'b0;
	logic        odd_r = 1'b0;
	logic [31:0] word;
	initial gnt_n = 1'b1;
	initial trdy_n = 1'b1;
	assign bus_frame_n = frame_oe_n | frame_n_o;
	assign bus_irdy_n  = irdy_oe_n | irdy_n_o;
	assign word        = BASE + 32'(idx_r);
	// Undriven data lines show the inverse while trdy_n is high, so a late capture cannot match.
	assign ad_in = !ad_oe_n ? ad_o : (trdy_n ? ~word : word);
	always @(posedge core_clk) begin
		gnt_n <= req_n;
		odd_r <= ~odd_r;
		if (!bus_irdy_n && !trdy_n && bus_frame_n) begin
			sel_r  <= 1'b0;
			trdy_n <= 1'b1;
			idx_r  <= idx_r + 16'h1;
		end else begin
			if (!bus_irdy_n && !trdy_n)
				idx_r <= idx_r + 16'h1;
			else if (!sel_r && bus_frame_n)
				idx_r <= 16'h0;
			if (!bus_frame_n)
				sel_r <= 1'b1;
			trdy_n <= !(sel_r || !bus_frame_n) || (slow && odd_r);
		end
	end
endmodule
